// file: verilog/epid_map.svh
`ifndef EPID_MAP_SVH
`define EPID_MAP_SVH

// apb register byte offsets
`define EPID_OFS_POWER 12'h000
`define EPID_OFS_MAKER_PART 12'h004
`define EPID_OFS_SUBSYS 12'h008
`define EPID_OFS_REV_CLASS 12'h00c
`define EPID_OFS_CFG_STATUS 12'h010

// wishbone word indices (ADR_I[4:2])
`define EPID_WB_SCRATCH 3'h0
`define EPID_WB_MAKER_PART 3'h1
`define EPID_WB_SUBSYS 3'h2
`define EPID_WB_REV_CLASS 3'h3
`define EPID_WB_POWER 3'h4

// field positions
`define EPID_POWER_LSB 0
`define EPID_POWER_MSB 1
`define EPID_STAT_LOADED 0
`define EPID_STAT_STROBE 1

// reset values
`define EPID_RST_POWER 2'h0
`define EPID_RST_CODE16 16'h0000
`define EPID_RST_REV 8'h00
`define EPID_RST_CLASS 24'h000000
`define EPID_RST_WORD 32'h00000000

`endif

// file: verilog/epid_pkg.sv
package epid_pkg;

  typedef enum logic [1:0] {
    EPID_D0 = 2'b00,
    EPID_D1 = 2'b01,
    EPID_D2 = 2'b10,
    EPID_D3 = 2'b11
  } epid_power_e;

  typedef struct packed {
    logic [15:0] maker;
    logic [15:0] part;
    logic [15:0] sub_maker;
    logic [15:0] sub_part;
    logic [7:0] revision;
    logic [23:0] category;
  } epid_ident_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [12:0] adr;
    logic [31:0] dat;
  } epid_wb_req_s;

endpackage

// file: verilog/epid_wb_slave.sv
`timescale 1ns/1ps
`include "epid_map.svh"

module epid_wb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone request and chain
  input epid_pkg::epid_wb_req_s req,
  input wire logic [31:0] chain_dat,
  input wire logic chain_ack,
  // state shown to the bus
  input epid_pkg::epid_ident_s ident,
  input wire logic [1:0] power,
  // answers
  output logic ack,
  output logic [31:0] dat_out
);
  import epid_pkg::*;

  logic ack_reg, ack_next;
  logic [31:0] scratch_reg, scratch_next;
  logic [31:0] rdat_reg, rdat_next;
  logic take;

  // one ack per strobed cycle; the gap cycle keeps a held strobe from double acking
  assign take = req.cyc & req.stb & ~ack_reg;

  always_comb begin
    ack_next = take;
    scratch_next = scratch_reg;
    rdat_next = rdat_reg;
    // only the scratch word is writable; every other index ignores writes
    if (take && req.we && req.adr[4:2] == `EPID_WB_SCRATCH) begin
      for (int i = 0; i < 4; i++) begin
        if (req.sel[i]) begin
          scratch_next[i*8 +: 8] = req.dat[i*8 +: 8];
        end
      end
    end
    if (take && !req.we) begin
      case (req.adr[4:2])
        `EPID_WB_SCRATCH: rdat_next = scratch_reg;
        `EPID_WB_MAKER_PART: rdat_next = {ident.part, ident.maker};
        `EPID_WB_SUBSYS: rdat_next = {ident.sub_part, ident.sub_maker};
        `EPID_WB_REV_CLASS: rdat_next = {ident.category, ident.revision};
        `EPID_WB_POWER: rdat_next = {30'h0, power};
        default: rdat_next = `EPID_RST_WORD;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (!req.sel[i]) begin
          rdat_next[i*8 +: 8] = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      scratch_reg <= `EPID_RST_WORD;
      rdat_reg <= `EPID_RST_WORD;
    end else begin
      ack_reg <= ack_next;
      scratch_reg <= scratch_next;
      rdat_reg <= rdat_next;
    end
  end

  // own answer wins; otherwise the previous slave's read passes through the chain
  assign ack = ack_reg | chain_ack;
  assign dat_out = ack_reg ? rdat_reg : chain_dat;

endmodule

// file: verilog/epid_top.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "epid_map.svh"

module epid_top #(
  parameter bit LOAD_FROM_PORTS = 1'b1
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // power state
  output logic [1:0] POWER_STATE_OUT,
  // identity load
  input wire logic IDENTITY_LOAD_STROBE,
  input wire logic [15:0] MAKER_CODE_IN,
  input wire logic [15:0] PART_CODE_IN,
  input wire logic [7:0] REVISION_CODE_IN,
  input wire logic [23:0] CATEGORY_CODE_IN,
  input wire logic [15:0] SUBSYSTEM_MAKER_IN,
  input wire logic [15:0] SUBSYSTEM_PART_IN,
  // configuration request and completion
  input wire logic CFG_REQ_VALID,
  output logic CFG_CPL_VALID,
  output logic CFG_CPL_RETRY,
  // wishbone slave
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [12:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAISY_READ_WORD_IN,
  input wire logic DAISY_ACK_IN,
  output logic ACK_O,
  output logic IRQ_O,
  output logic [31:0] DAT_O
);
  import epid_pkg::*;

  // reset image of the identity registers
  localparam epid_ident_s IDENT_RST = '{
    `EPID_RST_CODE16, `EPID_RST_CODE16, `EPID_RST_CODE16, `EPID_RST_CODE16,
    `EPID_RST_REV, `EPID_RST_CLASS
  };

  // identity capture
  epid_ident_s ident_in;
  epid_ident_s ident_reg, ident_next;
  logic strobe_eff, strobe_rise;
  logic strobe_reg, strobe_next;
  logic loaded_reg, loaded_next;

  // configuration completions
  logic cpl_valid_reg, cpl_valid_next;
  logic cpl_retry_reg, cpl_retry_next;

  // apb register file
  logic apb_setup, apb_access, apb_wr, apb_rd, hit;
  logic [31:0] rd_word;
  epid_power_e power_reg, power_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;

  // wishbone side
  logic wb_rst_n;
  epid_wb_req_s wb_req;

  // with the option off the strobe counts as high: answers succeed at once and the
  // identity keeps its reset image, since the vectors never reach the registers
  generate
    if (LOAD_FROM_PORTS) begin : g_port_load
      assign strobe_eff = IDENTITY_LOAD_STROBE;
      assign ident_in = '{MAKER_CODE_IN, PART_CODE_IN, SUBSYSTEM_MAKER_IN,
                          SUBSYSTEM_PART_IN, REVISION_CODE_IN, CATEGORY_CODE_IN};
    end else begin : g_fixed_ident
      assign strobe_eff = 1'b1;
      assign ident_in = IDENT_RST;
    end
  endgenerate

  // the strobe history resets low, so a strobe already high at release still loads
  assign strobe_rise = strobe_eff & ~strobe_reg;

  always_comb begin
    strobe_next = strobe_eff;
    ident_next = ident_reg;
    loaded_next = loaded_reg;
    if (LOAD_FROM_PORTS && strobe_rise) begin
      ident_next = ident_in;
      loaded_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      strobe_reg <= 1'b0;
      loaded_reg <= 1'b0;
      ident_reg <= IDENT_RST;
    end else begin
      strobe_reg <= strobe_next;
      loaded_reg <= loaded_next;
      ident_reg <= ident_next;
    end
  end

  // one completion per request, one cycle later; its status follows the strobe level
  always_comb begin
    cpl_valid_next = CFG_REQ_VALID;
    cpl_retry_next = 1'b0;
    if (CFG_REQ_VALID) begin
      if (strobe_eff) begin
        cpl_retry_next = 1'b0;
      end else begin
        cpl_retry_next = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cpl_valid_reg <= 1'b0;
      cpl_retry_reg <= 1'b0;
    end else begin
      cpl_valid_reg <= cpl_valid_next;
      cpl_retry_reg <= cpl_retry_next;
    end
  end

  // apb phases: one setup cycle, then a single access cycle
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE;
  assign apb_wr = apb_access & PWRITE;
  assign apb_rd = apb_setup & ~PWRITE;

  // address decode shared by reads and the error flag
  always_comb begin
    rd_word = `EPID_RST_WORD;
    hit = 1'b1;
    case (PADDR)
      `EPID_OFS_POWER: rd_word = {30'h0, power_reg};
      `EPID_OFS_MAKER_PART: rd_word = {ident_reg.part, ident_reg.maker};
      `EPID_OFS_SUBSYS: rd_word = {ident_reg.sub_part, ident_reg.sub_maker};
      `EPID_OFS_REV_CLASS: rd_word = {ident_reg.category, ident_reg.revision};
      `EPID_OFS_CFG_STATUS: rd_word = {30'h0, strobe_reg, loaded_reg};
      default: begin
        rd_word = `EPID_RST_WORD;
        hit = 1'b0;
      end
    endcase
  end

  // read data is prepared in the setup cycle so pready can stay high with no wait
  // state; the word then stands until the next read
  always_comb begin
    power_next = power_reg;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (apb_rd) begin
      prdata_next = rd_word;
    end
    if (apb_setup) begin
      slverr_next = ~hit;
    end
    // writes anywhere else, mapped or not, leave every register but the error flag as it is
    if (apb_wr && PADDR == `EPID_OFS_POWER) begin
      power_next = epid_power_e'(PWDATA[`EPID_POWER_MSB:`EPID_POWER_LSB]);
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      power_reg <= epid_power_e'(`EPID_RST_POWER);
      prdata_reg <= `EPID_RST_WORD;
      slverr_reg <= 1'b0;
    end else begin
      power_reg <= power_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access & slverr_reg;
  assign POWER_STATE_OUT = power_reg;
  assign CFG_CPL_VALID = cpl_valid_reg;
  assign CFG_CPL_RETRY = cpl_retry_reg;

  // either reset clears the wishbone side; it acts without the clock
  assign wb_rst_n = RESETN & ~RST_I;
  assign wb_req = '{CYC_I, STB_I, WE_I, SEL_I, ADR_I, DAT_I};
  assign IRQ_O = 1'b0;

  // chain inputs are expected tied low when no previous slave exists
  epid_wb_slave u_wb (
    .clk(MCLK),
    .rst_n(wb_rst_n),
    .req(wb_req),
    .chain_dat(DAISY_READ_WORD_IN),
    .chain_ack(DAISY_ACK_IN),
    .ident(ident_reg),
    .power(power_reg),
    .ack(ACK_O),
    .dat_out(DAT_O)
  );

endmodule

// file: tb/epid_top_monitor.sv
`timescale 1ns/1ps
module epid_top_monitor (
  // clock and apb
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PSLVERR,
  // side band
  input wire logic [1:0] POWER_STATE_OUT,
  input wire logic IDENTITY_LOAD_STROBE,
  input wire logic CFG_REQ_VALID,
  input wire logic CFG_CPL_VALID,
  input wire logic CFG_CPL_RETRY,
  // wishbone
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic DAISY_ACK_IN,
  input wire logic ACK_O,
  input wire logic IRQ_O
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_retry_low: assert property (CFG_REQ_VALID && !IDENTITY_LOAD_STROBE
    |=> CFG_CPL_VALID && CFG_CPL_RETRY) else $error("retry answer missing");
  a_success_high: assert property (CFG_REQ_VALID && IDENTITY_LOAD_STROBE
    |=> CFG_CPL_VALID && !CFG_CPL_RETRY) else $error("success answer missing");
  a_no_stray_cpl: assert property (!CFG_REQ_VALID |=> !CFG_CPL_VALID)
    else $error("completion without request");
  a_ack_next: assert property (disable iff (!RESETN || RST_I)
    CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
  a_ack_single: assert property (disable iff (!RESETN || RST_I)
    ACK_O && !DAISY_ACK_IN |=> !ACK_O || DAISY_ACK_IN) else $error("ack too long");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  // power moves only on a write
  a_power_hold: assert property (!(PSEL && PENABLE && PWRITE) && !(CYC_I && WE_I)
    |=> $stable(POWER_STATE_OUT)) else $error("power state moved");
  a_irq_zero: assert property (!IRQ_O) else $error("irq raised");
endmodule

bind epid_top epid_top_monitor u_mon (.MCLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PSLVERR,
  .POWER_STATE_OUT, .IDENTITY_LOAD_STROBE, .CFG_REQ_VALID, .CFG_CPL_VALID, .CFG_CPL_RETRY,
  .RST_I, .CYC_I, .STB_I, .WE_I, .DAISY_ACK_IN, .ACK_O, .IRQ_O);

// file: tb/epid_wb_master.sv
`timescale 1ns/1ps
module epid_wb_master (
  // clock
  input wire logic clk,
  // request and answer
  output epid_pkg::epid_wb_req_s req,
  input wire logic ack,
  input wire logic [31:0] dat_o
);
  import epid_pkg::*;
  initial req = '0;
  // caller enters just after an edge; strobe drops on the ack edge
  task automatic xfer(input logic we, input logic [3:0] sel, input logic [2:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output bit ok);
    int n;
    ok = 0;
    req <= '{1'b1, 1'b1, we, sel, {8'h0, idx, 2'h0}, wd};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = ack;
    end
    rd = dat_o;
    // released lines carry garbage, never the old word
    req <= '{1'b0, 1'b0, ~we, ~sel, ~req.adr, ~wd};
    @(posedge clk);
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "epid_map.svh"
module testbench;
  import epid_pkg::*;
  logic MCLK = 0;
  logic RESETN = 0;
  logic psel = 0, penable = 0, pwrite = 0, strobe = 0, req = 0, rst_i = 0, daisy_ack = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, daisy_dat = '0, prdata, rd, dat_o;
  logic pready, pslverr, cpl, retry, ack, irq, e;
  logic [1:0] pwr;
  logic [15:0] mk = '0, pt = '0, sm = '0, sp = '0;
  logic [7:0] rv = '0;
  logic [23:0] cat = '0;
  logic [3:0] rows [4] = '{{2'h0, EPID_D0}, {2'h1, EPID_D1}, {2'h2, EPID_D2}, {2'h3, EPID_D3}};
  epid_wb_req_s wb;
  int n_errors = 0, comparisons = 0;
  bit ok;
  epid_top DUT (.MCLK(MCLK), .RESETN(RESETN), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .POWER_STATE_OUT(pwr), .IDENTITY_LOAD_STROBE(strobe),
    .MAKER_CODE_IN(mk), .PART_CODE_IN(pt), .REVISION_CODE_IN(rv), .CATEGORY_CODE_IN(cat),
    .SUBSYSTEM_MAKER_IN(sm), .SUBSYSTEM_PART_IN(sp), .CFG_REQ_VALID(req),
    .CFG_CPL_VALID(cpl), .CFG_CPL_RETRY(retry), .RST_I(rst_i), .CYC_I(wb.cyc),
    .STB_I(wb.stb), .WE_I(wb.we), .SEL_I(wb.sel), .ADR_I(wb.adr), .DAT_I(wb.dat),
    .DAISY_READ_WORD_IN(daisy_dat), .DAISY_ACK_IN(daisy_ack), .ACK_O(ack), .IRQ_O(irq),
    .DAT_O(dat_o));
  epid_wb_master wbm (.clk(MCLK), .req(wb), .ack(ack), .dat_o(dat_o));
  always #10 MCLK = ~MCLK;
  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input bit good);
    if (!good) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge MCLK);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge MCLK);
      if (pready === 1'b1) break;
    end
    done(n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge MCLK);
  endtask
  task automatic wbx(input logic we, input logic [3:0] s, input logic [2:0] i,
    input logic [31:0] d);
    wbm.xfer(we, s, i, d, rd, ok);
    done(ok);
  endtask
  task automatic cfg(input logic x);
    req <= 1;
    @(posedge MCLK);
    req <= 0;
    @(posedge MCLK);
    chk({cpl, retry}, {1'b1, x});
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    chk(pwr, 0);
    RESETN <= 1;
    @(posedge MCLK);
    cfg(1);
    apb(0, `EPID_OFS_CFG_STATUS, 0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1, `EPID_OFS_POWER, rows[i][3:2]);
      chk(pwr, rows[i][1:0]);
      wbx(0, 4'hf, `EPID_WB_POWER, 0);
      chk(rd, rows[i][1:0]);
    end
    {mk, pt, sm, sp, rv, cat} <= {64'h1a2b3c4d5e6f7081, 32'h92a3b4c5};
    strobe <= 1;
    repeat (2) @(posedge MCLK);
    {mk, pt, sm, sp, rv, cat} <= '0;
    apb(1, `EPID_OFS_MAKER_PART, 32'hffffffff);
    apb(0, `EPID_OFS_MAKER_PART, 0);
    chk(rd, 32'h3c4d1a2b);
    apb(0, `EPID_OFS_SUBSYS, 0);
    chk(rd, 32'h70815e6f);
    apb(0, `EPID_OFS_REV_CLASS, 0);
    chk(rd, 32'ha3b4c592);
    apb(0, `EPID_OFS_CFG_STATUS, 0);
    chk(rd, 32'h3);
    wbx(0, 4'hf, `EPID_WB_MAKER_PART, 0);
    chk(rd, 32'h3c4d1a2b);
    wbx(0, 4'h6, `EPID_WB_MAKER_PART, 0);
    chk(rd, 32'h004d1a00);
    cfg(0);
    apb(0, 12'h020, 32'hffffffff);
    chk(e, 1);
    chk(rd, 0);
    wbx(1, 4'h9, `EPID_WB_SCRATCH, 32'haabbccdd);
    wbx(1, 4'hf, `EPID_WB_MAKER_PART, 32'h11223344);
    wbx(0, 4'hf, `EPID_WB_SCRATCH, 0);
    chk(rd, 32'haa0000dd);
    wbx(0, 4'hf, 3'h5, 0);
    chk(rd, 0);
    rst_i <= 1;
    @(posedge MCLK);
    rst_i <= 0;
    @(posedge MCLK);
    wbx(0, 4'hf, `EPID_WB_SCRATCH, 0);
    chk(rd, 0);
    daisy_dat <= 32'h5a5a0001;
    daisy_ack <= 1;
    @(posedge MCLK);
    chk(ack, 1);
    chk(dat_o, 32'h5a5a0001);
    daisy_ack <= 0;
    daisy_dat <= 32'ha5a5fffe;
    wbx(0, 4'hf, `EPID_WB_SCRATCH, 0);
    chk(rd, 0);
    chk(irq, 0);
    report_and_stop();
  end
endmodule
